// [rtl/fll_pkg.sv]
package fll_pkg;
  localparam logic [2:0] REG_CONF = 3'h0;
  localparam logic [2:0] REG_MUL = 3'h1;
  localparam logic [2:0] REG_STEP = 3'h2;
  localparam logic [2:0] REG_SPREAD = 3'h3;
  localparam logic [2:0] REG_RATIO = 3'h4;
  localparam logic [2:0] REG_SYNC = 3'h5;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int CONF_EN = 0;
  localparam int CONF_MODE = 1;
  localparam int CONF_DITHER = 2;
  localparam int CONF_WAKE_DROP = 3;
  localparam int CONF_CHILL = 5;
  localparam int CONF_QUICK = 6;
  localparam int FINE_LO = 8;
  localparam int FINE_W = 9;
  localparam int COARSE_LO = 24;
  localparam int COARSE_W = 8;
  localparam int MUL_W = 32;
  localparam int STEP_FINE_LO = 16;
  localparam int STEP_COARSE_LO = 0;
  localparam int SPR_EN = 0;
  localparam int SPR_RAND = 1;
  localparam int SPR_AMP_LO = 8;
  localparam int SPR_INC_LO = 16;
  localparam int FIELD5_W = 5;
  localparam int RATIO_ERR_LO = 16;
  localparam int ERR_W = 16;
  localparam int EXP_LO = 0;
  localparam int SYNC_BIT = 0;
  localparam int FRAC_SHIFT = 16;
  localparam int FINE_SHIFT = 8;
  localparam int DITH_W = 8;
  localparam int DITH_FRAC_LO = 8;
  localparam int CNT_W = 32;
  localparam int ACC_W = 49;
  localparam logic [8:0] COARSE_MAX = 9'h0ff;
  localparam logic [8:0] FINE_MAX = 9'h1ff;
  typedef enum logic [1:0] {
    FLL_IDLE = 2'b00,
    FLL_COUNT = 2'b01,
    FLL_CALC = 2'b11
  } fll_state_t;
endpackage : fll_pkg

// [rtl/fll_core_if.sv]
`timescale 1ns/10ps
interface fll_core_if;
  logic ref_tick;
  logic osc_tick;
  logic run;
  logic drop_locks;
  logic [4:0] window_exp;
  logic [31:0] mul;
  logic [7:0] coarse_max;
  logic [8:0] fine_max;
  logic [7:0] coarse;
  logic [8:0] fine;
  logic upd;
  logic [7:0] coarse_new;
  logic [8:0] fine_new;
  logic [15:0] err;
  logic lock_c;
  logic lock_f;
  modport core (input ref_tick, osc_tick, run, drop_locks, window_exp, mul, coarse_max,
    fine_max, coarse, fine, output upd, coarse_new, fine_new, err, lock_c, lock_f);
  modport ctl (output ref_tick, osc_tick, run, drop_locks, window_exp, mul, coarse_max,
    fine_max, coarse, fine, input upd, coarse_new, fine_new, err, lock_c, lock_f);
endinterface : fll_core_if

// [rtl/fll_engine.sv]
`timescale 1ns/10ps
module fll_engine (
  input wire logic clk,
  input wire logic nrst,
  fll_core_if.core cif
);
  fll_pkg::fll_state_t state_reg;
  fll_pkg::fll_state_t state_next;
  logic [31:0] ref_cnt_reg;
  logic [31:0] osc_cnt_reg;
  logic upd_reg;
  logic [7:0] coarse_new_reg;
  logic [8:0] fine_new_reg;
  logic [15:0] err_reg;
  logic lock_c_reg;
  logic lock_f_reg;

  function automatic logic [8:0] cap(input logic [48:0] mag, input logic [8:0] lim);
    cap = (mag > {40'h00_0000_0000, lim}) ? lim : mag[8:0];
  endfunction : cap

  function automatic logic [8:0] move(input logic [8:0] cur, input logic [8:0] stp,
                                      input logic down, input logic [8:0] top);
    logic [9:0] sum;
    sum = 10'h000;
    if (down) begin
      move = (cur < stp) ? 9'h000 : cur - stp;
    end else begin
      sum = {1'b0, cur} + {1'b0, stp};
      move = (sum > {1'b0, top}) ? top : sum[8:0];
    end
  endfunction : move

  function automatic logic [48:0] mag49(input logic [48:0] v);
    mag49 = v[48] ? (~v + 49'h0_0000_0000_0001) : v;
  endfunction : mag49

  // Window is 2^exp reference cycles
  wire [31:0] win_last = (32'h0000_0001 << cif.window_exp) - 32'h0000_0001;
  wire win_done = cif.ref_tick && (ref_cnt_reg == win_last);
  wire [48:0] meas = {1'b0, osc_cnt_reg, 16'h0000} >> cif.window_exp;
  wire [48:0] err_full = meas - {17'h0_0000, cif.mul};
  wire [48:0] err_int = {{fll_pkg::FRAC_SHIFT{err_full[48]}}, err_full[48:fll_pkg::FRAC_SHIFT]};
  wire [48:0] err_fin = {{fll_pkg::FINE_SHIFT{err_full[48]}}, err_full[48:fll_pkg::FINE_SHIFT]};
  wire int_zero = (err_int == 49'h0_0000_0000_0000);
  wire fin_zero = (err_fin == 49'h0_0000_0000_0000);
  wire sat_hi = !err_int[48] && (err_int[47:15] != 33'h0_0000_0000);
  wire sat_lo = err_int[48] && (err_int[47:15] != {33{1'b1}});
  wire [15:0] err_sat = sat_hi ? 16'h7fff : (sat_lo ? 16'h8000 : err_int[15:0]);
  // Fast oscillator gives positive error, so codes move down
  wire [8:0] c_step = cap(mag49(err_int), {1'b0, cif.coarse_max});
  wire [8:0] f_step = cap(mag49(err_fin), cif.fine_max);
  wire [8:0] c_move = move({1'b0, cif.coarse}, c_step, err_full[48] == 1'b0, fll_pkg::COARSE_MAX);
  wire [8:0] f_move = move(cif.fine, f_step, err_full[48] == 1'b0, fll_pkg::FINE_MAX);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fll_pkg::FLL_IDLE: state_next = cif.run ? fll_pkg::FLL_COUNT : fll_pkg::FLL_IDLE;
      fll_pkg::FLL_COUNT: begin
        if (!cif.run) state_next = fll_pkg::FLL_IDLE;
        else if (win_done) state_next = fll_pkg::FLL_CALC;
      end
      fll_pkg::FLL_CALC: state_next = cif.run ? fll_pkg::FLL_COUNT : fll_pkg::FLL_IDLE;
      default: state_next = fll_pkg::FLL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= fll_pkg::FLL_IDLE;
      ref_cnt_reg <= 32'h0000_0000;
      osc_cnt_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      ref_cnt_reg <= (state_reg != fll_pkg::FLL_COUNT) ? 32'h0000_0000 :
                     ref_cnt_reg + {31'h0000_0000, cif.ref_tick};
      osc_cnt_reg <= (state_reg != fll_pkg::FLL_COUNT) ? 32'h0000_0000 :
                     osc_cnt_reg + {31'h0000_0000, cif.osc_tick};
    end
  end

  // Coarse first, then fine once the integer error is zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      upd_reg <= 1'b0;
      coarse_new_reg <= 8'h00;
      fine_new_reg <= 9'h000;
      err_reg <= 16'h0000;
      lock_c_reg <= 1'b0;
      lock_f_reg <= 1'b0;
    end else begin
      upd_reg <= (state_reg == fll_pkg::FLL_CALC) && cif.run;
      if (state_reg == fll_pkg::FLL_CALC) begin
        err_reg <= err_sat;
        coarse_new_reg <= int_zero ? cif.coarse : c_move[7:0];
        fine_new_reg <= int_zero ? f_move : cif.fine;
      end
      if (cif.drop_locks || !cif.run) begin
        lock_c_reg <= 1'b0;
        lock_f_reg <= 1'b0;
      end else if (state_reg == fll_pkg::FLL_CALC) begin
        lock_c_reg <= int_zero;
        lock_f_reg <= int_zero && fin_zero;
      end
    end
  end

  assign cif.upd = upd_reg;
  assign cif.coarse_new = coarse_new_reg;
  assign cif.fine_new = fine_new_reg;
  assign cif.err = err_reg;
  assign cif.lock_c = lock_c_reg;
  assign cif.lock_f = lock_f_reg;

  coarse_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    cif.upd |-> (cif.coarse_new - $past(cif.coarse) <= $past(cif.coarse_max)) ||
                ($past(cif.coarse) - cif.coarse_new <= $past(cif.coarse_max)))
    else $error("coarse step above limit");
  fine_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    cif.upd && cif.fine_new >= $past(cif.fine) |->
      cif.fine_new - $past(cif.fine) <= $past(cif.fine_max))
    else $error("fine step above limit");
  coarse_first_a: assert property (@(posedge clk) disable iff (!nrst)
    cif.upd && cif.coarse_new != $past(cif.coarse) |-> cif.fine_new == $past(cif.fine))
    else $error("fine moved during coarse step");
  wake_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    cif.drop_locks |=> !cif.lock_c && !cif.lock_f)
    else $error("lock held after wake");
endmodule : fll_engine

// [rtl/fll_regs.sv]
`timescale 1ns/10ps
module fll_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic ref_tick,
  input wire logic osc_tick,
  input wire logic wake_event,
  output logic loop_enable,
  output logic closed_loop,
  output logic [7:0] coarse_out,
  output logic [8:0] fine_out,
  output logic quick_lock_en,
  output logic chill_cycle_en,
  output logic spread_generator_en,
  output logic pseudo_random_interval,
  output logic [4:0] spread_increment,
  output logic [4:0] spread_amplitude,
  output logic lock_coarse,
  output logic lock_fine,
  output logic sync_ready
);
  fll_core_if cif ();

  logic [31:0] conf_reg;
  logic [7:0] coarse_reg;
  logic [8:0] fine_reg;
  logic [31:0] mul_reg;
  logic [31:0] step_reg;
  logic [31:0] spread_reg;
  logic [4:0] exp_reg;
  logic [7:0] sh_coarse_reg;
  logic [8:0] sh_fine_reg;
  logic [15:0] sh_err_reg;
  logic sync_pend_reg;
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic [7:0] dith_acc_reg;
  logic [8:0] fine_out_reg;
  logic [7:0] coarse_out_reg;
  logic [31:0] outs_reg;
  logic [31:0] spread_out_reg;
  logic lock_c_reg;
  logic lock_f_reg;

  wire wr_conf = reg_wr && (reg_addr == fll_pkg::REG_CONF);
  wire wr_mul = reg_wr && (reg_addr == fll_pkg::REG_MUL);
  wire wr_step = reg_wr && (reg_addr == fll_pkg::REG_STEP);
  wire wr_spread = reg_wr && (reg_addr == fll_pkg::REG_SPREAD);
  wire wr_ratio = reg_wr && (reg_addr == fll_pkg::REG_RATIO);
  wire wr_sync = reg_wr && (reg_addr == fll_pkg::REG_SYNC) && reg_wdata[fll_pkg::SYNC_BIT];
  wire en_bit = conf_reg[fll_pkg::CONF_EN];
  wire closed = conf_reg[fll_pkg::CONF_MODE];
  wire run = en_bit && closed;
  wire [7:0] wr_coarse = reg_wdata[fll_pkg::COARSE_LO +: fll_pkg::COARSE_W];
  wire [8:0] wr_fine = reg_wdata[fll_pkg::FINE_LO +: fll_pkg::FINE_W];
  // Control bits only; calibration fields live in their own registers
  wire [31:0] conf_mask = (32'h0000_0001 << fll_pkg::CONF_EN) |
                          (32'h0000_0001 << fll_pkg::CONF_MODE) |
                          (32'h0000_0001 << fll_pkg::CONF_DITHER) |
                          (32'h0000_0001 << fll_pkg::CONF_WAKE_DROP) |
                          (32'h0000_0001 << fll_pkg::CONF_CHILL) |
                          (32'h0000_0001 << fll_pkg::CONF_QUICK);
  wire [31:0] step_mask = ({23'h00_0000, fll_pkg::FINE_MAX} << fll_pkg::STEP_FINE_LO) |
                          ({23'h00_0000, fll_pkg::COARSE_MAX} << fll_pkg::STEP_COARSE_LO);
  wire [31:0] spread_mask = (32'h0000_001f << fll_pkg::SPR_INC_LO) |
                            (32'h0000_001f << fll_pkg::SPR_AMP_LO) |
                            (32'h0000_0001 << fll_pkg::SPR_RAND) |
                            (32'h0000_0001 << fll_pkg::SPR_EN);

  // Closed loop reads the synchronised snapshot, never the moving value
  wire [7:0] rd_coarse = closed ? sh_coarse_reg : coarse_reg;
  wire [8:0] rd_fine = closed ? sh_fine_reg : fine_reg;
  wire [15:0] rd_err = closed ? sh_err_reg : 16'h0000;
  wire [31:0] conf_word = (conf_reg & conf_mask) |
                          ({24'h00_0000, rd_coarse} << fll_pkg::COARSE_LO) |
                          ({23'h00_0000, rd_fine} << fll_pkg::FINE_LO);
  wire [31:0] ratio_word = ({16'h0000, rd_err} << fll_pkg::RATIO_ERR_LO) |
                           ({27'h000_0000, exp_reg} << fll_pkg::EXP_LO);
  wire [31:0] rd_word = (reg_addr == fll_pkg::REG_CONF) ? conf_word :
                        (reg_addr == fll_pkg::REG_MUL) ? mul_reg :
                        (reg_addr == fll_pkg::REG_STEP) ? step_reg :
                        (reg_addr == fll_pkg::REG_SPREAD) ? spread_reg :
                        (reg_addr == fll_pkg::REG_RATIO) ? ratio_word : fll_pkg::RESET_WORD;

  // Dither carry from the fractional factor; sub-LSB on average
  wire [8:0] dith_sum = {1'b0, dith_acc_reg} +
                        {1'b0, mul_reg[fll_pkg::DITH_FRAC_LO +: fll_pkg::DITH_W]};
  wire dith_on = conf_reg[fll_pkg::CONF_DITHER] && en_bit;
  wire dith_carry = dith_on && dith_sum[fll_pkg::DITH_W] && (fine_reg != fll_pkg::FINE_MAX);

  assign cif.ref_tick = ref_tick;
  assign cif.osc_tick = osc_tick;
  assign cif.run = run;
  assign cif.drop_locks = wake_event && conf_reg[fll_pkg::CONF_WAKE_DROP];
  assign cif.window_exp = exp_reg;
  assign cif.mul = mul_reg;
  assign cif.coarse_max = step_reg[fll_pkg::STEP_COARSE_LO +: fll_pkg::COARSE_W];
  assign cif.fine_max = step_reg[fll_pkg::STEP_FINE_LO +: fll_pkg::FINE_W];
  assign cif.coarse = coarse_reg;
  assign cif.fine = fine_reg;

  fll_engine u_engine (
    .clk(clk),
    .nrst(nrst),
    .cif(cif.core)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      conf_reg <= fll_pkg::RESET_WORD;
      mul_reg <= fll_pkg::RESET_WORD;
      step_reg <= fll_pkg::RESET_WORD;
      spread_reg <= fll_pkg::RESET_WORD;
      exp_reg <= 5'h00;
    end else begin
      if (wr_conf) conf_reg <= reg_wdata & conf_mask;
      if (wr_mul && closed) mul_reg <= reg_wdata;
      if (wr_step) step_reg <= reg_wdata & step_mask;
      if (wr_spread) spread_reg <= reg_wdata & spread_mask;
      if (wr_ratio) exp_reg <= reg_wdata[fll_pkg::EXP_LO +: fll_pkg::FIELD5_W];
    end
  end

  // Bus owns calibration in open loop, the engine in closed loop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      coarse_reg <= 8'h00;
      fine_reg <= 9'h000;
    end else if (!closed && wr_conf) begin
      coarse_reg <= wr_coarse;
      fine_reg <= wr_fine;
    end else if (closed && cif.upd) begin
      coarse_reg <= cif.coarse_new;
      fine_reg <= cif.fine_new;
    end
  end

  // Snapshot one cycle after the sync write; ready set wins over clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_pend_reg <= 1'b0;
      ready_reg <= 1'b0;
      sh_coarse_reg <= 8'h00;
      sh_fine_reg <= 9'h000;
      sh_err_reg <= 16'h0000;
    end else begin
      sync_pend_reg <= wr_sync;
      if (sync_pend_reg) begin
        sh_coarse_reg <= coarse_reg;
        sh_fine_reg <= fine_reg;
        sh_err_reg <= cif.err;
        ready_reg <= 1'b1;
      end else if (wr_sync) begin
        ready_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= fll_pkg::RESET_WORD;
      dith_acc_reg <= 8'h00;
      fine_out_reg <= 9'h000;
      coarse_out_reg <= 8'h00;
      outs_reg <= fll_pkg::RESET_WORD;
      spread_out_reg <= fll_pkg::RESET_WORD;
      lock_c_reg <= 1'b0;
      lock_f_reg <= 1'b0;
    end else begin
      if (reg_rd) rdata_reg <= rd_word;
      dith_acc_reg <= dith_on ? dith_sum[fll_pkg::DITH_W-1:0] : 8'h00;
      fine_out_reg <= fine_reg + {8'h00, dith_carry};
      coarse_out_reg <= coarse_reg;
      outs_reg <= conf_reg;
      spread_out_reg <= spread_reg;
      lock_c_reg <= cif.lock_c;
      lock_f_reg <= cif.lock_f;
    end
  end

  // One output copy per register, since both use bits 0 and 1
  assign reg_rdata = rdata_reg;
  assign loop_enable = outs_reg[fll_pkg::CONF_EN];
  assign closed_loop = outs_reg[fll_pkg::CONF_MODE];
  assign coarse_out = coarse_out_reg;
  assign fine_out = fine_out_reg;
  assign quick_lock_en = outs_reg[fll_pkg::CONF_QUICK];
  assign chill_cycle_en = outs_reg[fll_pkg::CONF_CHILL];
  assign spread_generator_en = spread_out_reg[fll_pkg::SPR_EN];
  assign pseudo_random_interval = spread_out_reg[fll_pkg::SPR_RAND];
  assign spread_increment = spread_out_reg[fll_pkg::SPR_INC_LO +: fll_pkg::FIELD5_W];
  assign spread_amplitude = spread_out_reg[fll_pkg::SPR_AMP_LO +: fll_pkg::FIELD5_W];
  assign lock_coarse = lock_c_reg;
  assign lock_fine = lock_f_reg;
  assign sync_ready = ready_reg;

  sequence sync_req_s;
    wr_sync ##1 !ready_reg;
  endsequence
  sync_ready_a: assert property (@(posedge clk) disable iff (!nrst)
    sync_req_s |=> ready_reg && sh_coarse_reg == $past(coarse_reg))
    else $error("sync snapshot or ready missing");
  mul_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_mul && !closed |=> $stable(mul_reg))
    else $error("multiplier changed in open loop");
  cal_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    closed && wr_conf && !cif.upd |=> $stable(coarse_reg) && $stable(fine_reg))
    else $error("calibration written in closed loop");
  cal_write_a: assert property (@(posedge clk) disable iff (!nrst)
    !closed && wr_conf |=> coarse_reg == $past(wr_coarse) && fine_reg == $past(wr_fine))
    else $error("open loop calibration write lost");
  dither_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !conf_reg[fll_pkg::CONF_DITHER] ##1 $stable(fine_reg) |-> fine_out == $past(fine_reg))
    else $error("fine output moved without dither");
  open_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !$past(closed) |-> !cif.upd)
    else $error("adjustment in open loop");
endmodule : fll_regs

// [sim/fll_regs_tb_top.sv]
`timescale 1ns/10ps
module fll_regs_tb_top;
  logic clk;
  logic nrst;
  logic [2:0] reg_addr;
  logic reg_wr, reg_rd, ref_tick, osc_tick, wake_event;
  logic [31:0] reg_wdata, reg_rdata, rv, mv;
  logic loop_enable, closed_loop, quick_lock_en, chill_cycle_en;
  logic spread_generator_en, pseudo_random_interval, lock_coarse, lock_fine, sync_ready;
  logic [7:0] coarse_out, prev_c, c_hold;
  logic [8:0] fine_out, prev_f, f_hold;
  logic [4:0] spread_increment, spread_amplitude;
  logic mon_on, osc_on;
  int miscompares, comparisons, ref_div, ref_cnt, cyc, last_chg, n_chg, n;

  fll_regs i_fll_regs (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_tick(ref_tick),
    .osc_tick(osc_tick), .wake_event(wake_event), .loop_enable(loop_enable),
    .closed_loop(closed_loop), .coarse_out(coarse_out), .fine_out(fine_out),
    .quick_lock_en(quick_lock_en), .chill_cycle_en(chill_cycle_en),
    .spread_generator_en(spread_generator_en), .pseudo_random_interval(pseudo_random_interval),
    .spread_increment(spread_increment), .spread_amplitude(spread_amplitude),
    .lock_coarse(lock_coarse), .lock_fine(lock_fine), .sync_ready(sync_ready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rdchk(input string name, input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask : rdchk

  // Bounded wait: sel 0 watches sync_ready, sel 1 watches lock_coarse
  task automatic wait_for(input int sel, input logic val, input int limit);
    logic s;
    for (int i = 0; i < limit; i++) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? sync_ready : lock_coarse;
      if (s === val) return;
    end
    miscompares++;
    $display("[ERR] wait %0d expected %b seen timeout", sel, val);
    summarize();
  endtask : wait_for

  task automatic count_fine(output int cnt);
    logic [8:0] p;
    cnt = 0;
    p = fine_out;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (fine_out !== p) cnt++;
      p = fine_out;
    end
  endtask : count_fine

  task automatic wake;
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
  endtask : wake

  // Synthetic clocks: osc every cycle, ref every ref_div cycles, so ratio is ref_div
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_cnt <= (ref_div == 0 || ref_cnt >= ref_div - 1) ? 0 : ref_cnt + 1;
    ref_tick <= (ref_div != 0) && (ref_cnt == 0);
    osc_tick <= osc_on;
  end

  // Step monitor; fine code may move either way, so both wrap directions are bounded
  always @(negedge clk) begin
    if (mon_on && coarse_out !== prev_c) begin
      n_chg++;
      mv = {31'h0, coarse_out < prev_c && (prev_c - coarse_out) <= 8'h02};
      chk("coarse_step", 32'h1, mv);
      mv = {31'h0, cyc - last_chg >= 32 && cyc - last_chg <= 40};
      if (n_chg > 1) chk("window_gap", 32'h1, mv);
      last_chg = cyc;
    end
    if (mon_on && fine_out !== prev_f) begin
      mv = {31'h0, (fine_out - prev_f) <= 9'h003 || (prev_f - fine_out) <= 9'h003};
      chk("fine_step", 32'h1, mv);
    end
    prev_c = coarse_out;
    prev_f = fine_out;
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 3'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
    ref_tick = 1'b0;
    osc_tick = 1'b0;
    wake_event = 1'b0;
    mon_on = 1'b0;
    osc_on = 1'b0;
    ref_div = 0;
    ref_cnt = 0;
    cyc = 0;
    n_chg = 0;
    miscompares = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    rv = {10'h0, coarse_out, fine_out, loop_enable, closed_loop, lock_coarse, lock_fine, sync_ready};
    chk("reset_outs", 32'h0, rv);
    for (int i = 0; i < 5; i++) rdchk("reset_reg", i[2:0], 32'h0000_0000);
    for (int i = 6; i < 8; i++) begin
      wr(i[2:0], 32'hFFFF_FFFF);
      rdchk("unmapped", i[2:0], 32'h0000_0000);
    end
    wr(fll_pkg::REG_CONF, 32'hA5FF_C3FD);
    rdchk("conf", fll_pkg::REG_CONF, 32'hA501_C36D);
    rv = {11'h0, coarse_out, fine_out, loop_enable, closed_loop, quick_lock_en, chill_cycle_en};
    chk("conf_outs", 32'h0014_BC3B, rv);
    wr(fll_pkg::REG_MUL, 32'h0001_2345);
    rdchk("mul_open", fll_pkg::REG_MUL, 32'h0000_0000);
    wr(fll_pkg::REG_STEP, 32'hFFFF_FFFF);
    rdchk("step", fll_pkg::REG_STEP, 32'h01FF_00FF);
    wr(fll_pkg::REG_STEP, 32'h0003_0002);
    wr(fll_pkg::REG_SPREAD, 32'hFFFF_FFFF);
    rdchk("spread", fll_pkg::REG_SPREAD, 32'h001F_1F03);
    rv = {20'h0, spread_increment, spread_amplitude, pseudo_random_interval, spread_generator_en};
    chk("spread_outs", 32'h0000_0FFF, rv);
    wr(fll_pkg::REG_SPREAD, 32'h0005_0A02);
    rdchk("spread", fll_pkg::REG_SPREAD, 32'h0005_0A02);
    rv = {20'h0, spread_increment, spread_amplitude, pseudo_random_interval, spread_generator_en};
    chk("spread_outs", 32'h0000_02AA, rv);
    wr(fll_pkg::REG_RATIO, 32'hFFFF_FFFF);
    rdchk("ratio_open", fll_pkg::REG_RATIO, 32'h0000_001F);
    wr(fll_pkg::REG_RATIO, 32'h0000_0002);
    wr(fll_pkg::REG_CONF, 32'hA501_C303);
    repeat (2) @(posedge clk);
    #1;
    rv = {28'h0, loop_enable, closed_loop, quick_lock_en, chill_cycle_en};
    chk("closed_outs", 32'h0000_000C, rv);
    wr(fll_pkg::REG_MUL, 32'h1234_5678);
    rdchk("mul", fll_pkg::REG_MUL, 32'h1234_5678);
    wr(fll_pkg::REG_MUL, 32'h0004_0000);
    osc_on = 1'b1;
    ref_div = 8;
    mon_on = 1'b1;
    repeat (300) @(posedge clk);
    mon_on = 1'b0;
    ref_div = 0;
    osc_on = 1'b0;
    chk("adjusted", 32'h1, {31'h0, n_chg > 2});
    repeat (4) @(posedge clk);
    #1;
    c_hold = coarse_out;
    f_hold = fine_out;
    wr(fll_pkg::REG_CONF, 32'h1100_0003);
    repeat (3) @(posedge clk);
    #1;
    chk("cal_locked", {15'h0, c_hold, f_hold}, {15'h0, coarse_out, fine_out});
    wr(fll_pkg::REG_SYNC, 32'h0000_0001);
    wait_for(0, 1'b1, 20);
    rd(fll_pkg::REG_CONF, rv);
    chk("sync_conf", {24'h0, c_hold}, {24'h0, rv[31:24]});
    rd(fll_pkg::REG_RATIO, rv);
    rv = {25'h0, rv[31], rv[31:16] != 16'h0000, rv[4:0]};
    chk("ratio_closed", 32'h0000_0022, rv);
    // Window of 4 ref ticks at 4 cycles sees 15 osc ticks, so 3.75 locks exactly
    wr(fll_pkg::REG_MUL, 32'h0003_C000);
    osc_on = 1'b1;
    ref_div = 4;
    wait_for(1, 1'b1, 400);
    repeat (40) @(posedge clk);
    wake();
    repeat (6) @(posedge clk);
    #1;
    chk("lock_kept", 32'h3, {30'h0, lock_coarse, lock_fine});
    wr(fll_pkg::REG_CONF, 32'h0000_000B);
    wake();
    wait_for(1, 1'b0, 6);
    chk("lock_drop", 32'h0, {31'h0, lock_fine});
    ref_div = 0;
    wr(fll_pkg::REG_MUL, 32'h0004_8000);
    wr(fll_pkg::REG_CONF, 32'h0000_0007);
    count_fine(n);
    chk("dither_on", 32'h1, {31'h0, n > 0});
    wr(fll_pkg::REG_CONF, 32'h0000_0003);
    repeat (2) @(posedge clk);
    count_fine(n);
    chk("dither_off", 32'h0, n);
    summarize();
  end
endmodule : fll_regs_tb_top
